// ===== sepr_dev.sv
`timescale 1ns/1ps
`include "sepr_regs.svh"
module sepr_dev
    import sepr_pkg::*;
#(
    parameter int AW       = 6,
    parameter int DW       = 16,
    parameter int PROG_CYC = `SEPR_PROG_CYC
) (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    sepr_if.dev       lnk,
    output logic      prog_busy,
    output logic      prog_enabled
);
    localparam int DEPTH = 1 << AW;

    // ----------------------------------------
    // pin synchronisers, three stages
    // ----------------------------------------
    logic [2:0] cs_s_r, ck_s_r, di_s_r;
    logic       cs_q_r, ck_q_r, di_q_r;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cs_s_r <= 3'h0;
            ck_s_r <= 3'h0;
            di_s_r <= 3'h0;
            cs_q_r <= 1'b0;
            ck_q_r <= 1'b0;
            di_q_r <= 1'b0;
        end else begin
            cs_s_r <= {cs_s_r[1:0], lnk.chip_sel};
            ck_s_r <= {ck_s_r[1:0], lnk.sclk};
            di_s_r <= {di_s_r[1:0], lnk.serial_in};
            if (cs_s_r[1] == cs_s_r[2]) cs_q_r <= cs_s_r[2];
            if (ck_s_r[1] == ck_s_r[2]) ck_q_r <= ck_s_r[2];
            if (di_s_r[1] == di_s_r[2]) di_q_r <= di_s_r[2];
        end
    end
    // delayed copies of the filtered pins for edge detection
    logic ck_d_r;
    logic cs_d_r;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ck_d_r <= 1'b0;
            cs_d_r <= 1'b0;
        end else begin
            ck_d_r <= ck_q_r;
            cs_d_r <= cs_q_r;
        end
    end
    wire ck_rise = ck_q_r & ~ck_d_r;
    wire cs_fall = ~cs_q_r & cs_d_r;

    // ----------------------------------------
    // storage and control state
    // ----------------------------------------
    logic [DW-1:0] mem_r [DEPTH];
    sepr_dev_e     st_r, st_nxt;
    logic [4:0]    cnt_r, cnt_nxt;
    logic [1:0]    op_r, op_nxt;
    logic [AW-1:0] adr_r, adr_nxt;
    logic [DW-1:0] sh_r, sh_nxt;
    logic          en_r, en_nxt;
    logic [1:0]    pk_r, pk_nxt;      // 0 none 1 word 2 erall 3 wrall
    logic [31:0]   tm_r, tm_nxt;
    logic          so_r, so_nxt, oen_r, oen_nxt;
    logic          busy_r;            // registered copy of the busy level

    // next-state logic
    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        op_nxt  = op_r;
        adr_nxt = adr_r;
        sh_nxt  = sh_r;
        en_nxt  = en_r;
        pk_nxt  = pk_r;
        tm_nxt  = tm_r;
        so_nxt  = so_r;
        oen_nxt = oen_r;
        // self-timed cycle runs regardless of select
        if (tm_r != 32'h0) begin
            tm_nxt = tm_r - 32'h1;
            if (tm_r == 32'h1) pk_nxt = 2'h0;
        end
        if (!cs_q_r) begin
            st_nxt = SEPR_IDLE;
            cnt_nxt = 5'h0;
            if (cs_fall) oen_nxt = 1'b1;
        end else begin
            // status after select rises during a cycle
            if (!cs_d_r && st_r == SEPR_IDLE && pk_r != 2'h0) begin
                oen_nxt = 1'b0;
                so_nxt  = 1'b0;                                   // no stale level on the first driven cycle
            end
            if (oen_r == 1'b0 && st_r != SEPR_READ) so_nxt = (pk_r == 2'h0);
            if (ck_rise) begin
                case (st_r)
                    SEPR_IDLE: if (di_q_r && pk_r == 2'h0) begin
                        st_nxt = SEPR_HDR;
                        cnt_nxt = 5'h0;
                        oen_nxt = 1'b1;
                    end
                    SEPR_HDR: begin
                        cnt_nxt = cnt_r + 5'h1;
                        if (cnt_r < 5'h2) op_nxt = {op_r[0], di_q_r};
                        else adr_nxt = {adr_r[AW-2:0], di_q_r};
                        if (cnt_r == 5'(`SEPR_HDR_BITS - 2)) begin
                            cnt_nxt = 5'h0;
                            st_nxt = SEPR_DONE;
                            case (op_r)
                                `SEPR_OP_READ: begin
                                    st_nxt = SEPR_READ;
                                    sh_nxt = mem_r[{adr_r[AW-2:0], di_q_r}];
                                    so_nxt = 1'b0;
                                    oen_nxt = 1'b0;
                                end
                                `SEPR_OP_WRITE: st_nxt = SEPR_DATA;
                                `SEPR_OP_ERASE: st_nxt = SEPR_DONE;
                                default: case (adr_r[AW-2:AW-3])
                                    `SEPR_EXT_DISABLE: en_nxt = 1'b0;
                                    `SEPR_EXT_ENABLE:  en_nxt = 1'b1;
                                    `SEPR_EXT_WRALL:   st_nxt = SEPR_DATA;
                                    default: if (en_r) begin
                                        pk_nxt = 2'h2;
                                        tm_nxt = 32'(PROG_CYC);
                                    end
                                endcase
                            endcase
                        end
                    end
                    SEPR_DATA: begin
                        sh_nxt = {sh_r[DW-2:0], di_q_r};
                        cnt_nxt = cnt_r + 5'h1;
                        if (cnt_r == 5'(DW - 1)) begin
                            st_nxt = SEPR_DONE;
                            if (en_r) begin
                                pk_nxt = (op_r == `SEPR_OP_WRITE) ? 2'h1 : 2'h3;
                                tm_nxt = 32'(PROG_CYC);
                            end
                        end
                    end
                    SEPR_READ: begin
                        so_nxt = sh_r[DW-1];
                        sh_nxt = {sh_r[DW-2:0], 1'b0};
                        cnt_nxt = cnt_r + 5'h1;
                        if (cnt_r == 5'(DW - 1)) begin
                            cnt_nxt = 5'h0;
                            adr_nxt = adr_r + 1'b1;
                            sh_nxt = mem_r[AW'(adr_r + 1'b1)];
                        end
                    end
                    SEPR_DONE: ;
                    default: st_nxt = SEPR_IDLE;
                endcase
            end
        end
    end

    // state registers; array written when the cycle ends
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r  <= SEPR_IDLE;
            cnt_r <= 5'h0;
            op_r  <= 2'h0;
            adr_r <= '0;
            sh_r  <= '0;
            en_r  <= 1'b0;
            pk_r  <= 2'h0;
            tm_r  <= 32'h0;
            so_r  <= 1'b1;
            oen_r <= 1'b1;
            busy_r <= 1'b0;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            op_r  <= op_nxt;
            adr_r <= adr_nxt;
            sh_r  <= sh_nxt;
            en_r  <= en_nxt;
            pk_r  <= pk_nxt;
            tm_r  <= tm_nxt;
            so_r  <= so_nxt;
            oen_r <= oen_nxt;
            busy_r <= (pk_nxt != 2'h0);
        end
    end
    always_ff @(posedge sys_clk) begin
        if (tm_r == 32'h1) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (pk_r == 2'h2) mem_r[i] <= `SEPR_ERASED_WORD;
                else if (pk_r == 2'h3) mem_r[i] <= sh_r;
                else if (AW'(i) == adr_r) mem_r[i] <= sh_r;
            end
        end
    end

    assign lnk.serial_out      = so_r;
    assign lnk.serial_out_oe_n = oen_r;
    assign prog_busy           = busy_r;
    assign prog_enabled        = en_r;
endmodule

// ===== sepr_regs.svh
`ifndef SEPR_REGS_SVH
`define SEPR_REGS_SVH
// Overview of operation
// - erase-all sets every array bit to one
// - erase-all starts on last address edge, self-timed
// - erase-all busy shown after select low 250ns
// - programming disabled after power-up
// - enable holds until disable or power loss
// - master should disable after programming
// - reads work whether enabled or disabled
// - read gives dummy zero then sixteen bits
// - read output bit changes each rising edge
// - held select continues read to next word
// - write shifts sixteen data bits after address
// - write self-times erase then program of word
// - write busy low, ready high after select
// - ready one when done, zero while programming
// - write-all programs every word with data
// - write-all starts on last data edge
// - write-all erases first, needs enable
// - write-all busy shown after select low 250ns
// - start bit: first edge with select, data high
// - select low resets control, cycle still completes
// - output released on select fall, else read/status
// - start, two-bit opcode, six address bits

// ----------------------------------------
// instruction coding
// ----------------------------------------
`define SEPR_OP_EXT        2'h0
`define SEPR_OP_WRITE      2'h1
`define SEPR_OP_READ       2'h2
`define SEPR_OP_ERASE      2'h3
`define SEPR_EXT_DISABLE   2'h0
`define SEPR_EXT_WRALL     2'h1
`define SEPR_EXT_ERALL     2'h2
`define SEPR_EXT_ENABLE    2'h3
`define SEPR_HDR_BITS      9
`define SEPR_DATA_BITS     16
`define SEPR_ERASED_WORD   16'hFFFF

// ----------------------------------------
// timing
// ----------------------------------------
`define SEPR_CLK_NS        10
`define SEPR_CSL_NS        250
`define SEPR_CSL_CYC       ((`SEPR_CSL_NS + `SEPR_CLK_NS - 1) / `SEPR_CLK_NS)
`define SEPR_PROG_US       2
`define SEPR_PROG_CYC      ((`SEPR_PROG_US * 1000) / `SEPR_CLK_NS)
`define SEPR_SCLK_DIV      6
`endif

// ===== sepr_pkg.sv
package sepr_pkg;
    typedef enum logic [2:0] {
        SEPR_IDLE  = 3'b000,
        SEPR_HDR   = 3'b001,
        SEPR_DATA  = 3'b011,
        SEPR_READ  = 3'b010,
        SEPR_DONE  = 3'b110
    } sepr_dev_e;
    typedef enum logic [2:0] {
        SEPR_M_IDLE = 3'b000,
        SEPR_M_SHFT = 3'b001,
        SEPR_M_GAP  = 3'b011,
        SEPR_M_POLL = 3'b010,
        SEPR_M_END  = 3'b110
    } sepr_mst_e;
endpackage

// ===== sepr_if.sv
`timescale 1ns/1ps
interface sepr_if;
    logic chip_sel;
    logic sclk;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe_n;
    modport dev (input chip_sel, input sclk, input serial_in, output serial_out, output serial_out_oe_n);
    modport mst (input serial_out, input serial_out_oe_n, output chip_sel, output sclk, output serial_in);
endinterface

// ===== sepr_mst.sv
`timescale 1ns/1ps
`include "sepr_regs.svh"
module sepr_mst
    import sepr_pkg::*;
#(
    parameter int DIV = `SEPR_SCLK_DIV
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    sepr_if.mst              lnk,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [1:0]  cmd_op,
    input  wire logic [5:0]  cmd_addr,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic [5:0]  cmd_rwords,
    output logic             rd_valid,
    input  wire logic        rd_ready,
    output logic [15:0]      rd_data,
    output logic             done
);
    // ----------------------------------------
    // framing and clock generation
    // ----------------------------------------
    sepr_mst_e   st_r, st_nxt;
    logic [40:0] sh_r, sh_nxt;
    logic [9:0]  bits_r, bits_nxt;
    logic [7:0]  dv_r, dv_nxt;
    logic        cs_r, cs_nxt, ck_r, ck_nxt, poll_r, poll_nxt;
    logic [15:0] rs_r, rs_nxt;
    logic [4:0]  rc_r, rc_nxt;
    logic        rd_r, rd_nxt;
    logic [2:0]  so_s_r;
    logic        so_q_r;
    logic [2:0]  oe_s_r;
    logic        oe_q_r;
    logic        rdop_r, rdop_nxt;   // command taken is a read
    logic [5:0]  nw_r, nw_nxt;       // words to read, held for the frame
    // two-entry read buffer
    logic [15:0] bf_r [2];
    logic [1:0]  bn_r;
    logic        bw_r, brd_r;
    wire         push = rd_r;
    wire         pop  = rd_valid & rd_ready;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            so_s_r <= 3'h0;
            so_q_r <= 1'b0;
            oe_s_r <= 3'h7;
            oe_q_r <= 1'b1;
        end else begin
            so_s_r <= {so_s_r[1:0], lnk.serial_out};
            if (so_s_r[1] == so_s_r[2]) so_q_r <= so_s_r[2];
            oe_s_r <= {oe_s_r[1:0], lnk.serial_out_oe_n};
            if (oe_s_r[1] == oe_s_r[2]) oe_q_r <= oe_s_r[2];
        end
    end

    // next-state logic
    always_comb begin
        st_nxt = st_r; sh_nxt = sh_r; bits_nxt = bits_r; dv_nxt = dv_r;
        cs_nxt = cs_r; ck_nxt = ck_r; poll_nxt = poll_r;
        rs_nxt = rs_r; rc_nxt = rc_r; rd_nxt = 1'b0;
        rdop_nxt = rdop_r;
        nw_nxt = nw_r;
        case (st_r)
            SEPR_M_IDLE: if (cmd_valid && cmd_ready) begin
                st_nxt = SEPR_M_SHFT;
                rdop_nxt = (cmd_op == `SEPR_OP_READ);
                nw_nxt = cmd_rwords;
                cs_nxt = 1'b1;
                dv_nxt = 8'h0;
                rc_nxt = 5'h0;
                sh_nxt = {1'b1, cmd_op, cmd_addr, cmd_wdata, 16'h0};
                poll_nxt = (cmd_op != `SEPR_OP_READ) && !(cmd_op == `SEPR_OP_EXT && cmd_addr[5] == cmd_addr[4]);
                if (cmd_op == `SEPR_OP_READ) bits_nxt = 10'(`SEPR_HDR_BITS + 1 + 16 * cmd_rwords);
                else if (cmd_op == `SEPR_OP_WRITE || (cmd_op == `SEPR_OP_EXT && cmd_addr[5:4] == `SEPR_EXT_WRALL))
                    bits_nxt = 10'(`SEPR_HDR_BITS + `SEPR_DATA_BITS);
                else bits_nxt = 10'(`SEPR_HDR_BITS);
            end
            SEPR_M_SHFT: if (rd_valid && bn_r == 2'h2) begin
                dv_nxt = dv_r;                                    // stall while buffer full
            end else begin
                dv_nxt = dv_r + 8'h1;
                if (dv_r == 8'(DIV - 1)) begin
                    dv_nxt = 8'h0;
                    ck_nxt = ~ck_r;
                    if (!ck_r) begin
                        bits_nxt = bits_r - 10'h1;
                    end else begin
                        sh_nxt = {sh_r[39:0], 1'b0};
                        if (bits_r == 10'h0) begin
                            st_nxt = SEPR_M_GAP;
                            cs_nxt = 1'b0;
                            ck_nxt = 1'b0;
                        end
                    end
                    if (!ck_r && rdop_r && bits_r <= 10'(16 * nw_r) && bits_r != 10'h0) begin
                        rs_nxt = {rs_r[14:0], so_q_r};
                        rc_nxt = rc_r + 5'h1;
                        if (rc_r == 5'hF) begin
                            rc_nxt = 5'h0;
                            rd_nxt = 1'b1;
                        end
                    end
                end
            end
            SEPR_M_GAP: begin
                dv_nxt = dv_r + 8'h1;
                if (dv_r == 8'(`SEPR_CSL_CYC + 4)) begin
                    dv_nxt = 8'h0;
                    if (poll_r) begin
                        cs_nxt = 1'b1;
                        st_nxt = SEPR_M_POLL;
                    end else st_nxt = SEPR_M_END;
                end
            end
            SEPR_M_POLL: begin
                dv_nxt = (dv_r == 8'hFF) ? dv_r : dv_r + 8'h1;
                // a released output reads as ready, so a refused program never hangs
                if (dv_r > 8'hC && (so_q_r || oe_q_r)) begin
                    cs_nxt = 1'b0;
                    st_nxt = SEPR_M_END;
                    dv_nxt = 8'h0;
                end
            end
            SEPR_M_END: begin
                dv_nxt = dv_r + 8'h1;
                if (dv_r == 8'(`SEPR_CSL_CYC + 4)) st_nxt = SEPR_M_IDLE;
            end
            default: st_nxt = SEPR_M_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r <= SEPR_M_IDLE; sh_r <= '0; bits_r <= '0; dv_r <= '0;
            cs_r <= 1'b0; ck_r <= 1'b0; poll_r <= 1'b0;
            rs_r <= '0; rc_r <= '0; rd_r <= 1'b0;
            rdop_r <= 1'b0;
            nw_r <= '0;
        end else begin
            st_r <= st_nxt; sh_r <= sh_nxt; bits_r <= bits_nxt; dv_r <= dv_nxt;
            cs_r <= cs_nxt; ck_r <= ck_nxt; poll_r <= poll_nxt;
            rs_r <= rs_nxt; rc_r <= rc_nxt; rd_r <= rd_nxt;
            rdop_r <= rdop_nxt;
            nw_r <= nw_nxt;
        end
    end

    // read buffer: push a word, pop to user
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bn_r <= 2'h0; bw_r <= 1'b0; brd_r <= 1'b0;
            bf_r[0] <= '0; bf_r[1] <= '0;
        end else begin
            if (push) begin
                bf_r[bw_r] <= rs_nxt;
                bw_r <= ~bw_r;
            end
            if (pop) brd_r <= ~brd_r;
            bn_r <= bn_r + 2'(push) - 2'(pop);
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_valid <= 1'b0; rd_data <= '0; cmd_ready <= 1'b0; done <= 1'b0;
        end else begin
            rd_valid  <= (bn_r + 2'(push) - 2'(pop)) != 2'h0;
            rd_data   <= (bn_r - 2'(pop) == 2'h0 && push) ? rs_nxt : bf_r[brd_r ^ pop];
            cmd_ready <= (st_nxt == SEPR_M_IDLE) && !(st_r == SEPR_M_IDLE && cmd_valid && cmd_ready);
            done      <= (st_r == SEPR_M_END) && (st_nxt == SEPR_M_IDLE);
        end
    end

    assign lnk.chip_sel  = cs_r;
    assign lnk.sclk      = ck_r;
    assign lnk.serial_in = sh_r[40];
endmodule

// ===== sepr_chk.sv
`timescale 1ns/1ps
module sepr_chk
    import sepr_pkg::*;
#(
    parameter int PROG_CYC = 200
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic chip_sel,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe_n,
    input wire logic prog_busy,
    input wire logic prog_enabled
);
    logic       sclk_r;
    logic [4:0] edg_r, edg_nxt;
    logic [8:0] hdr_r, hdr_nxt;
    logic [3:0] hi_r, hi_nxt;
    logic [7:0] bsy_r, bsy_nxt;
    logic       rise, erase_whole_array_go, write_whole_array_go, locked_wr, rd_go;

    // ----------------------------------------
    // frame tracking on the raw link signals
    // ----------------------------------------
    assign rise      = chip_sel && sclk && !sclk_r;
    assign erase_whole_array_go   = rise && edg_r == 5'd8 && hdr_r[6:3] == 4'h2 && prog_enabled;
    assign write_whole_array_go   = rise && edg_r == 5'd24 && hdr_r[7:4] == 4'h1 && prog_enabled;
    assign locked_wr = rise && edg_r == 5'd24 && (hdr_r[7:6] == 2'h1 || hdr_r[7:4] == 4'h1) && !prog_enabled;
    assign rd_go     = rise && edg_r == 5'd9 && hdr_r[7:6] == 2'h2;

    // next edge count, header bits, select-high time and busy length
    always_comb begin
        edg_nxt = edg_r;
        hdr_nxt = hdr_r;
        hi_nxt  = (hi_r == 4'hF) ? hi_r : hi_r + 4'h1;
        bsy_nxt = prog_busy ? bsy_r + 8'h01 : 8'h00;
        if (!chip_sel) begin
            edg_nxt = 5'd0;
            hdr_nxt = 9'h000;
            hi_nxt  = 4'h0;
        end else if (rise && edg_r != 5'd31) begin
            edg_nxt = edg_r + 5'd1;
            if (edg_r < 5'd9) begin
                hdr_nxt = {hdr_r[7:0], serial_in};
            end
        end
    end

    // registers only
    always_ff @(posedge sys_clk) begin
        sclk_r <= sys_rst ? 1'b0 : sclk;
        edg_r  <= sys_rst ? 5'd0 : edg_nxt;
        hdr_r  <= sys_rst ? 9'h000 : hdr_nxt;
        hi_r   <= sys_rst ? 4'h0 : hi_nxt;
        bsy_r  <= sys_rst ? 8'h00 : bsy_nxt;
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_start_bit_first: assert property (rise && edg_r == 5'd0 |-> serial_in)
        else $error("first clocked bit of a frame is not a start bit");
    a_erase_whole_array_starts_busy: assert property (erase_whole_array_go |-> ##[1:8] prog_busy)
        else $error("erase-all did not start its cycle");
    a_write_whole_array_starts_busy: assert property (write_whole_array_go |-> ##[1:8] prog_busy)
        else $error("write-all did not start its cycle");
    a_locked_no_prog: assert property (locked_wr |-> !prog_busy [*8])
        else $error("program cycle started while disabled");
    a_read_dummy_zero: assert property (rd_go |-> !serial_out_oe_n && !serial_out)
        else $error("read lacks the leading zero");
    a_poll_busy_low: assert property (chip_sel && edg_r == 5'd0 && hi_r >= 4'd8 && prog_busy
        |-> !serial_out_oe_n && !serial_out)
        else $error("status not low while busy");
    a_poll_ready_high: assert property ($fell(prog_busy) && chip_sel && edg_r == 5'd0
        |-> ##[0:4] (serial_out && !serial_out_oe_n))
        else $error("status not high after cycle end");
    a_out_release: assert property ($fell(chip_sel) |-> ##[1:8] serial_out_oe_n)
        else $error("output not released after deselect");
    a_busy_length: assert property ($fell(prog_busy) |-> bsy_r == 8'(PROG_CYC))
        else $error("self-timed cycle length wrong");

    c_erase_whole_array: cover property (erase_whole_array_go);
    c_write_whole_array: cover property (write_whole_array_go);
    c_locked: cover property (locked_wr);
    c_read: cover property (rd_go);
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    import sepr_pkg::*;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cmd_valid, cmd_ready, rd_valid, rd_ready, done, prog_busy, prog_enabled, en_m;
    logic [1:0]  cmd_op;
    logic [5:0]  cmd_addr, cmd_rwords;
    logic [15:0] cmd_wdata, rd_data;
    logic [15:0] mem_m [64];
    logic [15:0] got_q [$];
    int          num_errors = 0;
    int          samples_checked = 0;

    sepr_if i_sepr_if ();
    sepr_dev #(.PROG_CYC(50)) i_sepr_dev (.sys_clk(sys_clk), .sys_rst(sys_rst), .lnk(i_sepr_if.dev),
        .prog_busy(prog_busy), .prog_enabled(prog_enabled));
    sepr_mst i_sepr_mst (.sys_clk(sys_clk), .sys_rst(sys_rst), .lnk(i_sepr_if.mst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_rwords(cmd_rwords), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .done(done));
    sepr_chk #(.PROG_CYC(50)) i_sepr_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .chip_sel(i_sepr_if.chip_sel), .sclk(i_sepr_if.sclk), .serial_in(i_sepr_if.serial_in),
        .serial_out(i_sepr_if.serial_out), .serial_out_oe_n(i_sepr_if.serial_out_oe_n),
        .prog_busy(prog_busy), .prog_enabled(prog_enabled));

    // ----------------------------------------
    // clock, read collection, watchdog
    // ----------------------------------------
    always #5 sys_clk = ~sys_clk;

    // a word moves at the next rising edge when both are high now
    always @(negedge sys_clk) begin
        if (rd_valid === 1'b1 && rd_ready === 1'b1) got_q.push_back(rd_data);
    end

    initial begin
        #600_000;
        num_errors++;
        tally_and_finish();
    end

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one command through the master, read words optionally stalled
    task automatic cmd(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d, input logic [5:0] n,
                       input int stall);
        int k;
        k = 0;
        rd_ready   = (stall == 0);
        cmd_valid  = 1'b1;
        cmd_op     = op;
        cmd_addr   = a;
        cmd_wdata  = d;
        cmd_rwords = n;
        while (cmd_ready !== 1'b1 && k < 2000) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        if (k >= 2000) check("command taken", 16'h0001, 16'h0000);
        @(posedge sys_clk);
        #1;
        cmd_valid = 1'b0;
        repeat (stall) @(posedge sys_clk);
        #1;
        rd_ready = 1'b1;
        k = 0;
        while (done !== 1'b1 && k < 40000) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        if (k >= 40000) check("command done", 16'h0001, 16'h0000);
        repeat (4) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        cmd(2'h1, a, d, 6'd1, 0);
        if (en_m) mem_m[a] = d;
    endtask

    // extended command: 0 disable, 1 write-all, 2 erase-all, 3 enable
    task automatic ext(input logic [1:0] sel, input logic [15:0] d);
        cmd(2'h0, {sel, 4'h0}, d, 6'd1, 0);
        if (sel == 2'h3) en_m = 1'b1;
        if (sel == 2'h0) en_m = 1'b0;
        for (int i = 0; i < 64; i++) begin
            if (en_m && sel == 2'h2) mem_m[i] = 16'hFFFF;
            if (en_m && sel == 2'h1) mem_m[i] = d;
        end
        check("enable state", {15'h0000, en_m}, {15'h0000, prog_enabled});
    endtask

    task automatic rd(input logic [5:0] a, input logic [5:0] n, input int stall);
        got_q.delete();
        cmd(2'h2, a, 16'h0000, n, stall);
        check("read count", {10'h000, n}, 16'(got_q.size()));
        for (int i = 0; i < n && i < got_q.size(); i++) check("read word", mem_m[a + i], got_q[i]);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        cmd_valid  = 1'b0;
        cmd_op     = 2'h0;
        cmd_addr   = 6'h00;
        cmd_wdata  = 16'h0000;
        cmd_rwords = 6'd1;
        rd_ready   = 1'b1;
        en_m       = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        check("enable state", 16'h0000, {15'h0000, prog_enabled});
        ext(2'h3, 16'h0000);
        ext(2'h2, 16'h0000);
        rd(6'd0, 6'd63, 0);
        ext(2'h1, 16'hA5C3);
        rd(6'd60, 6'd3, 0);
        wr(6'd7, 16'h1234);
        wr(6'd8, 16'hFEDC);
        rd(6'd6, 6'd4, 1000);
        ext(2'h0, 16'h0000);
        wr(6'd7, 16'h0000);
        ext(2'h1, 16'h0000);
        ext(2'h2, 16'h0000);
        rd(6'd7, 6'd2, 0);
        rd(6'd63, 6'd1, 0);
        // reset in mid-run: enable is lost, stored words stay
        ext(2'h3, 16'h0000);
        sys_rst = 1'b1;
        en_m    = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        check("enable state", 16'h0000, {15'h0000, prog_enabled});
        rd(6'd8, 6'd1, 0);
        tally_and_finish();
    end
endmodule
